/* inc/strap_pkg.sv */
package strap_pkg;

	// ****************************************************************
	// Strap vector layout
	// ****************************************************************
	localparam int STRAP_W = 5;
	localparam int S_SPEED = 0;
	localparam int S_DUPLEX = 1;
	localparam int S_BACKPR = 2;
	localparam int S_PAUSE = 3;
	localparam int S_MANUAL = 4;

	// Tie-off defaults: speed, duplex, backpressure, pause high; manual low
	localparam logic [STRAP_W-1:0] STRAP_DEFAULT = 5'h0f;

	// ****************************************************************
	// Register field positions
	// ****************************************************************
	localparam int BC_SPEED_LSB_BIT = 13;
	localparam int BC_DUPLEX_BIT = 8;
	localparam int ADV_10FD_BIT = 6;
	localparam int ADV_10HD_BIT = 5;
	localparam int MODE_W = 3;

	// Mode field encodings for the special modes register
	localparam logic [MODE_W-1:0] MODE_10HD = 3'h0;
	localparam logic [MODE_W-1:0] MODE_10FD = 3'h1;
	localparam logic [MODE_W-1:0] MODE_100HD = 3'h2;
	localparam logic [MODE_W-1:0] MODE_100FD = 3'h3;

	// ****************************************************************
	// Software register map (byte addresses)
	// ****************************************************************
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFF_LATCHED = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_ACTIVE = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_OUTPUTS = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_FLOWCTL = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_CONTROL = 8'h10;

	// Control register bits (write only pulses)
	localparam int CTL_DIGITAL_RESET = 0;
	localparam int CTL_RELOAD = 1;

	// Pin synchroniser depth
	localparam int SYNC_STAGES = 2;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RESTORE = 2'b01,
		ST_LOADED = 2'b11
	} load_state_e;

endpackage

/* rtl/strap_capture.sv */
`timescale 1ns/100ps
// Holds the latched pin values apart from all configuration registers
module strap_capture
	import strap_pkg::*;
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic rstn_i,
	// Capture
	input wire logic capture_i,
	input wire logic [STRAP_W-1:0] pins_i,
	// Stored value
	output logic [STRAP_W-1:0] latched_o
);

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			latched_o <= STRAP_DEFAULT;
		end else if (capture_i) begin
			latched_o <= pins_i;
		end
	end

endmodule // strap_capture

/* rtl/port_link_strap_defaults.sv */
`timescale 1ns/100ps
// Summary of operation
// - Speed strap sets reset speed-select low bit; low 10 Mbps, high 100 Mbps.
// - Speed strap defaults high, so port comes up at 100 Mbps.
// - Speed strap also sets 10BASE-T full and half duplex advertisement bits.
// - Three-bit mode field derives from both speed and duplex straps.
// - Duplex strap sets reset duplex bit; low half, high full duplex.
// - Duplex strap defaults high, so port comes up full duplex.
// - Of the advertisement bits, duplex strap affects only the 10BASE-T full duplex bit.
// - Backpressure strap, default high, sets backpressure enable reset value.
// - Pause strap, default high, loads both transmit and receive pause enables.
// - Transmit and receive pause enables apply only under manual pause selection.
// - Straps latch at reset release; loader values override them.
// - Digital reset or reload without valid EEPROM restores latched values, no resample.
// - Manual strap high uses enable bits; low follows auto-negotiation results.
module port_link_strap_defaults
	import strap_pkg::*;
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic rstn_i,
	// Strap pins, asynchronous
	input wire logic port1_speed_default_pin_i,
	input wire logic port1_duplex_default_pin_i,
	input wire logic port1_backpressure_default_pin_i,
	input wire logic port1_pause_default_pin_i,
	input wire logic port1_manual_pause_select_pin_i,
	// Chip reset logic
	input wire logic digital_reset_i,
	// EEPROM loader
	input wire logic loader_valid_i,
	input wire logic [STRAP_W-1:0] loader_straps_i,
	input wire logic loader_done_i,
	input wire logic eeprom_usable_i,
	// Auto-negotiation results
	input wire logic an_pause_transmit_i,
	input wire logic an_pause_receive_i,
	// Register port
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	output logic [31:0] reg_rdata_o,
	// PHY register defaults
	output logic phy_rate_select_low_bit_o,
	output logic phy_halffull_bit_o,
	output logic adv_10_full_o,
	output logic adv_10_half_o,
	output logic [MODE_W-1:0] phy_mode_o,
	// Flow control register defaults and effective controls
	output logic port1_backpressure_enable_o,
	output logic port1_pause_transmit_enable_o,
	output logic port1_pause_receive_enable_o,
	output logic port1_manual_pause_control_o,
	output logic pause_transmit_active_o,
	output logic pause_receive_active_o,
	// Load status
	output logic defaults_valid_o
);

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [STRAP_W-1:0] pins_raw;
	logic [STRAP_W-1:0] pins_meta;
	logic [STRAP_W-1:0] pins_sync;

	assign pins_raw[S_SPEED] = port1_speed_default_pin_i;
	assign pins_raw[S_DUPLEX] = port1_duplex_default_pin_i;
	assign pins_raw[S_BACKPR] = port1_backpressure_default_pin_i;
	assign pins_raw[S_PAUSE] = port1_pause_default_pin_i;
	assign pins_raw[S_MANUAL] = port1_manual_pause_select_pin_i;

	genvar gi;
	generate
		for (gi = 0; gi < STRAP_W; gi++) begin : g_sync
			always_ff @(posedge clock_i) begin
				if (!rstn_i) begin
					pins_meta[gi] <= STRAP_DEFAULT[gi];
					pins_sync[gi] <= STRAP_DEFAULT[gi];
				end else begin
					pins_meta[gi] <= pins_raw[gi];
					pins_sync[gi] <= pins_meta[gi];
				end
			end
		end
	endgenerate

	// ****************************************************************
	// Capture after reset release
	// ****************************************************************
	// Wait for the synchroniser to carry post-release pin levels
	logic [1:0] settle;
	logic capture;
	logic captured;

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			settle <= 2'h0;
		end else if (settle != 2'h3) begin
			settle <= settle + 2'h1;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			captured <= 1'b0;
		end else if (capture) begin
			captured <= 1'b1;
		end
	end

	assign capture = (settle == 2'h2) && !captured;

	logic [STRAP_W-1:0] latched;

	strap_capture u_capture (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.capture_i(capture),
		.pins_i(pins_sync),
		.latched_o(latched)
	);

	// ****************************************************************
	// Software control
	// ****************************************************************
	logic wr_control;
	logic sw_digital_reset;
	logic sw_reload;
	logic restore_req;

	assign wr_control = reg_write_i && (reg_addr_i == OFF_CONTROL);
	assign sw_digital_reset = wr_control && reg_wdata_i[CTL_DIGITAL_RESET];
	assign sw_reload = wr_control && reg_wdata_i[CTL_RELOAD];
	assign restore_req = digital_reset_i || sw_digital_reset || sw_reload;

	// ****************************************************************
	// Active strap values
	// ****************************************************************
	load_state_e state;
	load_state_e next_state;
	logic [STRAP_W-1:0] active;

	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: begin
				if (captured) begin
					next_state = ST_RESTORE;
				end
			end
			ST_RESTORE: begin
				if (loader_valid_i) begin
					next_state = ST_LOADED;
				end else if (loader_done_i) begin
					next_state = ST_LOADED;
				end
			end
			ST_LOADED: begin
				if (restore_req) begin
					next_state = ST_RESTORE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Loader data win over latched pins; without a usable EEPROM the
	// originals come back without resampling the pins
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			active <= STRAP_DEFAULT;
		end else if (capture) begin
			active <= pins_sync;
		end else if (loader_valid_i && eeprom_usable_i && state != ST_IDLE) begin
			active <= loader_straps_i;
		end else if (restore_req && !eeprom_usable_i) begin
			active <= latched;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			defaults_valid_o <= 1'b0;
		end else begin
			defaults_valid_o <= (next_state == ST_LOADED);
		end
	end

	// ****************************************************************
	// Derived register defaults
	// ****************************************************************
	logic [MODE_W-1:0] next_mode;

	always_comb begin
		unique case ({active[S_SPEED], active[S_DUPLEX]})
			2'b00: next_mode = MODE_10HD;
			2'b01: next_mode = MODE_10FD;
			2'b10: next_mode = MODE_100HD;
			2'b11: next_mode = MODE_100FD;
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			phy_rate_select_low_bit_o <= STRAP_DEFAULT[S_SPEED];
			phy_halffull_bit_o <= STRAP_DEFAULT[S_DUPLEX];
			adv_10_full_o <= STRAP_DEFAULT[S_SPEED] && STRAP_DEFAULT[S_DUPLEX];
			adv_10_half_o <= STRAP_DEFAULT[S_SPEED];
			phy_mode_o <= MODE_100FD;
		end else begin
			phy_rate_select_low_bit_o <= active[S_SPEED];
			phy_halffull_bit_o <= active[S_DUPLEX];
			adv_10_full_o <= active[S_SPEED] && active[S_DUPLEX];
			adv_10_half_o <= active[S_SPEED];
			phy_mode_o <= next_mode;
		end
	end

	// ****************************************************************
	// Flow control
	// ****************************************************************
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			port1_backpressure_enable_o <= STRAP_DEFAULT[S_BACKPR];
			port1_pause_transmit_enable_o <= STRAP_DEFAULT[S_PAUSE];
			port1_pause_receive_enable_o <= STRAP_DEFAULT[S_PAUSE];
			port1_manual_pause_control_o <= STRAP_DEFAULT[S_MANUAL];
		end else begin
			port1_backpressure_enable_o <= active[S_BACKPR];
			port1_pause_transmit_enable_o <= active[S_PAUSE];
			port1_pause_receive_enable_o <= active[S_PAUSE];
			port1_manual_pause_control_o <= active[S_MANUAL];
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			pause_transmit_active_o <= 1'b0;
			pause_receive_active_o <= 1'b0;
		end else if (port1_manual_pause_control_o) begin
			pause_transmit_active_o <= port1_pause_transmit_enable_o;
			pause_receive_active_o <= port1_pause_receive_enable_o;
		end else begin
			pause_transmit_active_o <= an_pause_transmit_i;
			pause_receive_active_o <= an_pause_receive_i;
		end
	end

	// ****************************************************************
	// Register read port
	// ****************************************************************
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			reg_rdata_o <= 32'h0;
		end else if (reg_read_i) begin
			unique case (reg_addr_i)
				OFF_LATCHED: reg_rdata_o <= {27'h0, latched};
				OFF_ACTIVE: reg_rdata_o <= {27'h0, active};
				OFF_OUTPUTS: reg_rdata_o <= {26'h0, phy_mode_o, adv_10_full_o, adv_10_half_o,
					phy_halffull_bit_o};
				OFF_FLOWCTL: reg_rdata_o <= {26'h0, pause_receive_active_o, pause_transmit_active_o,
					port1_manual_pause_control_o, port1_pause_receive_enable_o,
					port1_pause_transmit_enable_o, port1_backpressure_enable_o};
				default: reg_rdata_o <= 32'h0;
			endcase
		end else begin
			reg_rdata_o <= 32'h0;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	sequence s_restore;
		restore_req && !eeprom_usable_i && !capture && !(loader_valid_i && state != ST_IDLE);
	endsequence

	a_restore_latched: assert property (@(posedge clock_i) disable iff (!rstn_i)
		s_restore |=> active == $past(latched))
		else $error("restore did not return latched straps");

	a_capture_pins: assert property (@(posedge clock_i) disable iff (!rstn_i)
		capture |=> active == $past(pins_sync) && latched == $past(pins_sync))
		else $error("strap capture failed");

	a_capture_once: assert property (@(posedge clock_i) disable iff (!rstn_i)
		captured && !capture |=> $stable(latched))
		else $error("latched straps changed after capture");

	a_speed_bit: assert property (@(posedge clock_i) disable iff (!rstn_i)
		##1 phy_rate_select_low_bit_o == $past(active[S_SPEED]))
		else $error("speed bit does not follow strap");

	a_duplex_bit: assert property (@(posedge clock_i) disable iff (!rstn_i)
		##1 phy_halffull_bit_o == $past(active[S_DUPLEX]))
		else $error("duplex bit does not follow strap");

	a_adv_bits: assert property (@(posedge clock_i) disable iff (!rstn_i)
		##1 adv_10_half_o == $past(active[S_SPEED]) && adv_10_full_o == $past(active[S_SPEED] & active[S_DUPLEX]))
		else $error("advertisement bits wrong");

	a_adv_half_dup: assert property (@(posedge clock_i) disable iff (!rstn_i)
		$changed(active[S_DUPLEX]) && $stable(active[S_SPEED]) |=> $stable(adv_10_half_o))
		else $error("duplex strap moved half duplex advertisement");

	a_mode_field: assert property (@(posedge clock_i) disable iff (!rstn_i)
		##1 phy_mode_o == {1'b0, $past(active[S_SPEED]), $past(active[S_DUPLEX])})
		else $error("mode field wrong");

	a_backpressure: assert property (@(posedge clock_i) disable iff (!rstn_i)
		##1 port1_backpressure_enable_o == $past(active[S_BACKPR]))
		else $error("backpressure enable wrong");

	a_pause_pair: assert property (@(posedge clock_i) disable iff (!rstn_i)
		##1 port1_pause_transmit_enable_o == $past(active[S_PAUSE])
		&& port1_pause_receive_enable_o == $past(active[S_PAUSE]))
		else $error("pause enables do not follow strap");

	a_manual_sel: assert property (@(posedge clock_i) disable iff (!rstn_i)
		port1_manual_pause_control_o |=> pause_transmit_active_o == $past(port1_pause_transmit_enable_o))
		else $error("manual pause not applied");

	a_auto_sel: assert property (@(posedge clock_i) disable iff (!rstn_i)
		!port1_manual_pause_control_o |=> pause_receive_active_o == $past(an_pause_receive_i))
		else $error("auto-negotiated pause not applied");

	a_reset_defaults: assert property (@(posedge clock_i)
		!rstn_i |=> phy_rate_select_low_bit_o && phy_halffull_bit_o)
		else $error("reset defaults not high");

	a_duplex_default: assert property (@(posedge clock_i)
		!rstn_i |=> active[S_DUPLEX] && port1_pause_transmit_enable_o)
		else $error("duplex default not high");

endmodule // port_link_strap_defaults

/* testbench/loader_model.sv */
`timescale 1ns/100ps
// Loader and reset partner: sends one strap word per request while present, otherwise only done, promptly or late
module loader_model (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rstn_i,
	// Commands from the bench
	input wire logic load_i,
	input wire logic slow_i,
	input wire logic present_i,
	input wire logic reset_req_i,
	input wire logic [4:0] data_i,
	// Toward the block
	output logic loader_valid_o,
	output logic [4:0] loader_straps_o,
	output logic loader_done_o,
	output logic eeprom_usable_o,
	output logic digital_reset_o
);
	logic [3:0] wait_cnt;
	logic busy;
	logic sent;
	assign eeprom_usable_o = present_i;
	always_ff @(posedge clock_i) begin
		digital_reset_o <= reset_req_i && rstn_i;
		loader_valid_o <= 1'b0;
		sent <= 1'b0;
		loader_done_o <= sent;
		// Released data lines never keep the last word
		loader_straps_o <= ~loader_straps_o;
		if (!rstn_i) begin
			busy <= 1'b0;
			wait_cnt <= 4'h0;
			loader_straps_o <= 5'h00;
		end else if (load_i) begin
			busy <= 1'b1;
			wait_cnt <= slow_i ? 4'h6 : 4'h0;
		end else if (busy && wait_cnt != 4'h0) begin
			wait_cnt <= wait_cnt - 4'h1;
		end else if (busy) begin
			busy <= 1'b0;
			sent <= 1'b1;
			loader_valid_o <= present_i;
			loader_straps_o <= data_i;
		end
	end
endmodule // loader_model

/* testbench/port_link_strap_defaults_tb.sv */
`timescale 1ns/100ps
module port_link_strap_defaults_tb;
	import strap_pkg::*;
	logic clock_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [STRAP_W-1:0] pins = STRAP_DEFAULT;
	logic an_tx = 1'b0;
	logic an_rx = 1'b0;
	logic [ADDR_W-1:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic load = 1'b0;
	logic slow = 1'b0;
	logic present = 1'b1;
	logic rreq = 1'b0;
	logic [4:0] ldata = 5'h00;
	logic lv, ld, lu, drst;
	logic [4:0] ls;
	logic [31:0] rdata;
	logic rate, hf, af_o, ah_o, bp, txe, rxe, man, tx_act, rx_act, dv;
	logic [MODE_W-1:0] mode;
	int n_mismatch = 0;
	int compares = 0;
	logic af [4];
	logic ah [4];

	always #2 clock_i = ~clock_i;

	loader_model partner (.clock_i(clock_i), .rstn_i(rstn_i), .load_i(load), .slow_i(slow), .present_i(present),
		.reset_req_i(rreq), .data_i(ldata), .loader_valid_o(lv), .loader_straps_o(ls), .loader_done_o(ld),
		.eeprom_usable_o(lu), .digital_reset_o(drst));

	port_link_strap_defaults dut (.clock_i(clock_i), .rstn_i(rstn_i),
		.port1_speed_default_pin_i(pins[S_SPEED]), .port1_duplex_default_pin_i(pins[S_DUPLEX]),
		.port1_backpressure_default_pin_i(pins[S_BACKPR]), .port1_pause_default_pin_i(pins[S_PAUSE]),
		.port1_manual_pause_select_pin_i(pins[S_MANUAL]), .digital_reset_i(drst), .loader_valid_i(lv),
		.loader_straps_i(ls), .loader_done_i(ld), .eeprom_usable_i(lu), .an_pause_transmit_i(an_tx),
		.an_pause_receive_i(an_rx), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_write_i(reg_write),
		.reg_read_i(reg_read), .reg_rdata_o(rdata), .phy_rate_select_low_bit_o(rate), .phy_halffull_bit_o(hf),
		.adv_10_full_o(af_o), .adv_10_half_o(ah_o), .phy_mode_o(mode), .port1_backpressure_enable_o(bp),
		.port1_pause_transmit_enable_o(txe), .port1_pause_receive_enable_o(rxe),
		.port1_manual_pause_control_o(man), .pause_transmit_active_o(tx_act), .pause_receive_active_o(rx_act),
		.defaults_valid_o(dv));

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic summarize;
		$display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask

	task automatic do_reset(input logic [4:0] p);
		@(posedge clock_i);
		rstn_i <= 1'b0;
		pins <= p;
		repeat (10) @(posedge clock_i);
		rstn_i <= 1'b1;
		tick(10);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock_i);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock_i);
		reg_read <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock_i);
		reg_write <= 1'b0;
	endtask

	task automatic load_word(input logic [4:0] v, input logic s);
		int k;
		@(posedge clock_i);
		ldata <= v;
		slow <= s;
		load <= 1'b1;
		@(posedge clock_i);
		load <= 1'b0;
		for (k = 0; k < 20 && ld !== 1'b1; k++)
			@(posedge clock_i);
		chk(ld, 1'b1);
		tick(3);
	endtask

	task automatic check_outs(input logic [4:0] s);
		logic [2:0] m;
		m = s[0] ? (s[1] ? MODE_100FD : MODE_100HD) : (s[1] ? MODE_10FD : MODE_10HD);
		chk(rate, s[S_SPEED]);
		chk(hf, s[S_DUPLEX]);
		chk(mode, m);
		chk(bp, s[S_BACKPR]);
		chk({txe, rxe}, {2{s[S_PAUSE]}});
		chk(man, s[S_MANUAL]);
		chk(ah_o, s[S_SPEED]);
		chk(af_o, s[S_SPEED] & s[S_DUPLEX]);
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_capture;
		logic [31:0] d;
		do_reset(STRAP_DEFAULT);
		check_outs(STRAP_DEFAULT);
		chk({rate, hf}, 2'b11);
		do_reset(5'h12);
		check_outs(5'h12);
		chk(dv, 1'b0);
		// No EEPROM: the loader finishes without data and the pins stay in force
		present <= 1'b0;
		load_word(5'h0d, 1'b0);
		present <= 1'b1;
		check_outs(5'h12);
		chk(dv, 1'b1);
		rd(OFF_LATCHED, d);
		chk(d, 32'h12);
	endtask

	task automatic t_sweep;
		logic [31:0] d;
		logic [2:0] b;
		logic [4:0] v;
		for (int i = 0; i < 8; i++) begin
			b = i[2:0];
			v = {b[1] ^ b[2], ~b[0], b[2], b[1:0]};
			load_word(v, b[0]);
			check_outs(v);
			rd(OFF_ACTIVE, d);
			chk(d, {27'h0, v});
			af[b[1:0]] = af_o;
			ah[b[1:0]] = ah_o;
		end
		chk(ah[0] === ah[2] && ah[1] === ah[3], 1'b1);
		chk(ah[0] !== ah[1], 1'b1);
		chk(af[0] !== af[2] || af[1] !== af[3], 1'b1);
		chk(af[0] !== af[1] || af[2] !== af[3], 1'b1);
	endtask

	task automatic t_pause;
		logic [31:0] d;
		load_word(5'h18, 1'b0);
		chk({tx_act, rx_act}, 2'b11);
		@(posedge clock_i);
		{an_tx, an_rx} <= 2'b11;
		load_word(5'h12, 1'b1);
		chk({tx_act, rx_act}, 2'b00);
		@(posedge clock_i);
		{an_tx, an_rx} <= 2'b10;
		load_word(5'h08, 1'b0);
		chk({tx_act, rx_act}, 2'b10);
		@(posedge clock_i);
		{an_tx, an_rx} <= 2'b01;
		tick(3);
		chk({tx_act, rx_act}, 2'b01);
		rd(OFF_FLOWCTL, d);
		chk(d, 32'h26);
	endtask

	task automatic t_restore;
		logic [31:0] d;
		load_word(5'h0d, 1'b0);
		@(posedge clock_i);
		pins <= 5'h0d;
		present <= 1'b0;
		rreq <= 1'b1;
		@(posedge clock_i);
		rreq <= 1'b0;
		tick(4);
		check_outs(5'h12);
		rd(OFF_ACTIVE, d);
		chk(d, 32'h12);
		present <= 1'b1;
		load_word(5'h0d, 1'b1);
		present <= 1'b0;
		wr(OFF_CONTROL, 32'h2);
		tick(3);
		rd(OFF_ACTIVE, d);
		chk(d, 32'h12);
		// Erased device: the loader finishes without data
		load_word(5'h01, 1'b0);
		rd(OFF_LATCHED, d);
		chk(d, 32'h12);
		chk(rate, 1'b0);
		present <= 1'b1;
	endtask

	task automatic t_regbus;
		logic [31:0] d;
		load_word(5'h0d, 1'b0);
		present <= 1'b0;
		wr(OFF_CONTROL, 32'h1);
		rd(OFF_ACTIVE, d);
		chk(d, 32'h12);
		present <= 1'b1;
		rd(8'h20, d);
		chk(d, 32'h0);
		wr(OFF_ACTIVE, 32'h1f);
		rd(OFF_ACTIVE, d);
		chk(d, 32'h12);
		tick(1);
		chk(rdata, 32'h0);
	endtask

	initial begin
		repeat (20000) @(posedge clock_i);
		n_mismatch++;
		summarize();
	end

	initial begin
		t_capture();
		t_sweep();
		t_pause();
		do_reset(5'h12);
		t_restore();
		t_regbus();
		summarize();
	end
endmodule // port_link_strap_defaults_tb
